// File: hw/ats_core.sv
// Security and request-sense command interpreter of the drive.
// Assumes the host obeys BSY and DRQ and writes one 256-word sector.
//
// Implementation choices: the address map and the address-and-strobe port.
`default_nettype none
module ats_core
    import ats_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic nv_init_i,
    input wire logic security_en_i,
    input wire logic [2:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sense_evt_i,
    input wire ats_cause_t sense_cause_i,
    output logic [15:0] rdata_o,
    output logic intrq_o,
    output logic erase_o,
    output logic wear_level_o
);
    // ----------------------------------------------------------------
    // Extended error encoding
    // ----------------------------------------------------------------
    function automatic logic [7:0] cause_code(input ats_cause_t c);
        logic [7:0] code;
        code = EXT_NONE;
        unique case (c)
            CAUSE_NONE: code = EXT_NONE;
            CAUSE_SELFTEST_OK: code = EXT_SELFTEST_OK;
            CAUSE_MISC: code = EXT_MISC;
            CAUSE_BAD_ADDR: code = EXT_BAD_ADDR;
            CAUSE_OVERFLOW: code = EXT_OVERFLOW;
            CAUSE_IDNF: code = EXT_IDNF;
            CAUSE_ABORTED: code = EXT_ABORTED;
            CAUSE_UNCORR: code = EXT_UNCORR;
            CAUSE_CORR: code = EXT_CORR;
            CAUSE_DIAG_FAIL: code = EXT_DIAG_FAIL;
            CAUSE_SPARE_OUT: code = EXT_SPARE_OUT;
            default: code = EXT_MISC;
        endcase
        return code;
    endfunction

    function automatic logic needs_sector(input logic [7:0] c);
        return (c == CMD_SET_PW) || (c == CMD_ERASE) || (c == CMD_DISABLE);
    endfunction

    ats_state_t state_r;
    ats_state_t state_nxt;
    ats_bus_t bus;
    logic id_master;
    logic pw_match;
    logic done;
    logic abort;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign id_master = state_r.ctl_word[CTL_ID_BIT];

    // Master is never accepted at maximum level
    always_comb begin
        if (id_master) begin
            pw_match = (state_r.rx_pw == state_r.master_pw) &&
                !state_r.level_max;
        end else begin
            pw_match = state_r.user_set &&
                (state_r.rx_pw == state_r.user_pw);
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        done = 1'b0;
        abort = 1'b0;
        state_nxt.erase = 1'b0;
        state_nxt.wear = 1'b0;
        state_nxt.rdata = 16'h0000;

        if (bus.rd) begin
            unique case (bus.addr)
                REG_DATA: state_nxt.rdata = 16'h0000;
                REG_ERR_FEAT: state_nxt.rdata = {8'h00, state_r.err};
                REG_SEC_COUNT: state_nxt.rdata = {8'h00, state_r.sec_count};
                REG_SEC_NUM: state_nxt.rdata = {8'h00, state_r.sec_num};
                REG_CYL_LOW: state_nxt.rdata = {8'h00, state_r.cyl_low};
                REG_CYL_HIGH: begin
                    state_nxt.rdata = {8'h00, state_r.cylinder_high_byte};
                end
                REG_DEV_HEAD: state_nxt.rdata = {8'h00, state_r.dev_head};
                REG_STAT_CMD: begin
                    state_nxt.rdata = 16'h0000;
                    state_nxt.rdata[ST_BSY] = (state_r.phase == ST_EXEC);
                    state_nxt.rdata[ST_DRDY] = 1'b1;
                    state_nxt.rdata[ST_DRQ] = (state_r.phase == ST_XFER);
                    state_nxt.rdata[ST_ERR] = state_r.err_flag;
                    state_nxt.intrq = 1'b0;
                end
            endcase
        end

        if (sense_evt_i) begin
            state_nxt.sense = cause_code(sense_cause_i);
        end

        unique case (state_r.phase)
            ST_IDLE: begin
                if (bus.wr) begin
                    unique case (bus.addr)
                        REG_DATA: ;
                        REG_ERR_FEAT: state_nxt.feature = bus.wdata[7:0];
                        REG_SEC_COUNT: state_nxt.sec_count = bus.wdata[7:0];
                        REG_SEC_NUM: state_nxt.sec_num = bus.wdata[7:0];
                        REG_CYL_LOW: state_nxt.cyl_low = bus.wdata[7:0];
                        REG_CYL_HIGH: begin
                            state_nxt.cylinder_high_byte = bus.wdata[7:0];
                        end
                        REG_DEV_HEAD: state_nxt.dev_head = bus.wdata[7:0];
                        REG_STAT_CMD: begin
                            state_nxt.cmd = bus.wdata[7:0];
                            state_nxt.word_cnt = 8'h00;
                            state_nxt.phase = needs_sector(bus.wdata[7:0]) ?
                                ST_XFER : ST_EXEC;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                if (bus.wr && bus.addr == REG_DATA) begin
                    if (state_r.word_cnt == 8'h00) begin
                        state_nxt.ctl_word = bus.wdata;
                    end else if (state_r.word_cnt <= PW_LAST_WORD) begin
                        state_nxt.rx_pw[state_r.word_cnt[3:0] -
                            PW_FIRST_WORD[3:0]] = bus.wdata;
                    end
                    state_nxt.word_cnt = state_r.word_cnt + 8'h01;
                    if (state_r.word_cnt == SECTOR_LAST_WORD) begin
                        state_nxt.phase = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                done = 1'b1;
                state_nxt.phase = ST_IDLE;
                unique case (state_r.cmd)
                    CMD_SENSE: begin
                        state_nxt.err = state_r.sense;
                        state_nxt.sense = EXT_NONE;
                    end
                    CMD_PREPARE: ;
                    CMD_FREEZE: begin
                        if (security_en_i) begin
                            state_nxt.frozen = 1'b1;
                            state_nxt.sec_count = 8'h00;
                        end else begin
                            state_nxt.wear = 1'b1;
                        end
                    end
                    CMD_SET_PW: begin
                        if (state_r.frozen) begin
                            abort = 1'b1;
                        end else if (id_master) begin
                            state_nxt.master_pw = state_r.rx_pw;
                        end else begin
                            // Lock is not armed here, only at next reset
                            state_nxt.user_pw = state_r.rx_pw;
                            state_nxt.user_set = 1'b1;
                            state_nxt.level_max =
                                state_r.ctl_word[CTL_LEVEL_BIT];
                        end
                    end
                    CMD_DISABLE: begin
                        if (state_r.frozen || !pw_match) begin
                            abort = 1'b1;
                        end else begin
                            state_nxt.user_set = 1'b0;
                            state_nxt.lock_en = 1'b0;
                        end
                    end
                    CMD_ERASE: begin
                        // Host arms this by a prepare just before
                        if (state_r.frozen || !state_r.prepared ||
                            !pw_match) begin
                            abort = 1'b1;
                        end else begin
                            state_nxt.user_set = 1'b0;
                            state_nxt.lock_en = 1'b0;
                            state_nxt.erase = 1'b1;
                        end
                    end
                    default: abort = 1'b1;
                endcase
            end
        endcase

        if (done) begin
            state_nxt.prepared = (state_r.cmd == CMD_PREPARE);
            state_nxt.intrq = 1'b1;
            state_nxt.err_flag = abort;
            if (abort) begin
                state_nxt.err = ERR_ABRT;
                state_nxt.sense = EXT_ABORTED;
            end else if (state_r.cmd != CMD_SENSE) begin
                state_nxt.err = 8'h00;
                // A clean finish leaves no stale code for the next sense
                if (!sense_evt_i) begin
                    state_nxt.sense = EXT_NONE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Passwords and level survive reset unless nv_init_i is set; frozen and prepare do not
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= state_r;
            state_r.phase <= ST_IDLE;
            state_r.frozen <= 1'b0;
            state_r.prepared <= 1'b0;
            state_r.lock_en <= state_r.user_set && !nv_init_i;
            state_r.err <= 8'h00;
            state_r.err_flag <= 1'b0;
            state_r.sense <= EXT_NONE;
            state_r.rdata <= 16'h0000;
            state_r.intrq <= 1'b0;
            state_r.erase <= 1'b0;
            state_r.wear <= 1'b0;
            state_r.word_cnt <= 8'h00;
            state_r.cmd <= 8'h00;
            if (nv_init_i) begin
                state_r.user_pw <= '0;
                state_r.master_pw <= '0;
                state_r.rx_pw <= '0;
                state_r.ctl_word <= 16'h0000;
                state_r.user_set <= 1'b0;
                state_r.level_max <= 1'b0;
                state_r.sec_count <= 8'h00;
                state_r.sec_num <= 8'h00;
                state_r.cyl_low <= 8'h00;
                state_r.cylinder_high_byte <= 8'h00;
                state_r.dev_head <= 8'h00;
                state_r.feature <= 8'h00;
            end
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata_o = state_r.rdata;
    assign intrq_o = state_r.intrq;
    assign erase_o = state_r.erase;
    assign wear_level_o = state_r.wear;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_cmd_wr(logic [7:0] c);
        state_r.phase == ST_IDLE && wr_i && addr_i == REG_STAT_CMD &&
            wdata_i[7:0] == c;
    endsequence

    sequence s_exec(logic [7:0] c);
        state_r.phase == ST_EXEC && state_r.cmd == c;
    endsequence

    a_sense_report: assert property (
        s_cmd_wr(CMD_SENSE) ##1 s_exec(CMD_SENSE) ##0 !sense_evt_i |=>
            state_r.err == $past(state_r.sense))
        else $error("sense code not placed in error register");
    a_disable_sector: assert property (
        s_cmd_wr(CMD_DISABLE) |=> state_r.phase == ST_XFER)
        else $error("disable password does not request a sector");
    a_master_kept: assert property (
        s_exec(CMD_DISABLE) |=> $stable(state_r.master_pw))
        else $error("disable password altered master password");
    a_erase_noprep: assert property (
        s_exec(CMD_ERASE) ##0 !state_r.prepared |=>
            state_r.err_flag && state_r.intrq && !state_r.erase)
        else $error("erase without prepare not aborted");
    a_frozen_reject: assert property (
        state_r.phase == ST_EXEC && state_r.frozen &&
            needs_sector(state_r.cmd) |=> state_r.err == ERR_ABRT)
        else $error("frozen device accepted a lock command");
    a_frozen_sticky: assert property (
        state_r.frozen |=> state_r.frozen)
        else $error("frozen state cleared without reset");
    a_freeze_done: assert property (
        s_cmd_wr(CMD_FREEZE) ##0 security_en_i ##1 security_en_i |=>
            state_r.frozen && state_r.sec_count == 8'h00 &&
            !state_r.err_flag)
        else $error("freeze lock did not freeze or clear count");
    a_wear_level: assert property (
        s_exec(CMD_FREEZE) ##0 !security_en_i |=>
            state_r.wear && $stable(state_r.frozen))
        else $error("F5h without security not handled as wear level");
    a_lock_deferred: assert property (
        s_exec(CMD_SET_PW) |=> $stable(state_r.lock_en))
        else $error("set password changed lock state at once");
    a_master_set: assert property (
        s_exec(CMD_SET_PW) ##0 (id_master && !state_r.frozen) |=>
            $stable(state_r.level_max) && $stable(state_r.user_set) &&
            state_r.master_pw == $past(state_r.rx_pw))
        else $error("master set altered level or lock");
    a_erase_mismatch: assert property (
        s_exec(CMD_ERASE) ##0 !pw_match |=>
            state_r.err_flag && !state_r.erase)
        else $error("erase accepted a wrong password");
    a_user_stored: assert property (
        s_exec(CMD_SET_PW) ##0 (!id_master && !state_r.frozen) |=>
            state_r.user_set && state_r.user_pw == $past(state_r.rx_pw))
        else $error("user password not stored");
    a_max_refuse: assert property (
        s_exec(CMD_DISABLE) ##0 (id_master && state_r.level_max) |=>
            state_r.err_flag && state_r.err == ERR_ABRT)
        else $error("master password accepted at maximum level");
    a_freeze_again: assert property (
        s_exec(CMD_FREEZE) ##0 (security_en_i && state_r.frozen) |=>
            state_r.frozen && !state_r.err_flag && state_r.intrq)
        else $error("freeze while frozen did not complete");
    a_abort_report: assert property (
        state_r.phase == ST_EXEC && abort |=>
            state_r.intrq && state_r.err == ERR_ABRT &&
            state_r.sense == EXT_ABORTED)
        else $error("rejected command not reported as aborted");
    a_sense_cleared: assert property (
        state_r.phase == ST_EXEC && !abort && !sense_evt_i &&
            state_r.cmd != CMD_SENSE |=> state_r.sense == EXT_NONE)
        else $error("successful command left a stale sense code");
endmodule
`default_nettype wire

// File: hw/ats_pkg.sv
// Constants, types and state layout of the security and sense command block.
// Assumes one 10 MHz clock and a task-file port with 16-bit data.
`default_nettype none
package ats_pkg;
    // ----------------------------------------------------------------
    // Task-file register indices
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_ERR_FEAT = 3'h1;
    localparam logic [2:0] REG_SEC_COUNT = 3'h2;
    localparam logic [2:0] REG_SEC_NUM = 3'h3;
    localparam logic [2:0] REG_CYL_LOW = 3'h4;
    localparam logic [2:0] REG_CYL_HIGH = 3'h5;
    localparam logic [2:0] REG_DEV_HEAD = 3'h6;
    localparam logic [2:0] REG_STAT_CMD = 3'h7;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SENSE = 8'h03;
    localparam logic [7:0] CMD_SET_PW = 8'hF1;
    localparam logic [7:0] CMD_PREPARE = 8'hF3;
    localparam logic [7:0] CMD_ERASE = 8'hF4;
    localparam logic [7:0] CMD_FREEZE = 8'hF5;
    localparam logic [7:0] CMD_DISABLE = 8'hF6;

    // ----------------------------------------------------------------
    // Extended error codes
    // ----------------------------------------------------------------
    localparam logic [7:0] EXT_NONE = 8'h00;
    localparam logic [7:0] EXT_SELFTEST_OK = 8'h01;
    localparam logic [7:0] EXT_MISC = 8'h09;
    localparam logic [7:0] EXT_BAD_ADDR = 8'h21;
    localparam logic [7:0] EXT_OVERFLOW = 8'h2F;
    localparam logic [7:0] EXT_UNCORR = 8'h11;
    localparam logic [7:0] EXT_CORR = 8'h18;
    localparam logic [7:0] EXT_DIAG_FAIL = 8'h05;
    localparam logic [7:0] EXT_IDNF = 8'h10;
    localparam logic [7:0] EXT_SPARE_OUT = 8'h3A;
    localparam logic [7:0] EXT_ABORTED = 8'h1F;

    // ----------------------------------------------------------------
    // Register bits and sector layout
    // ----------------------------------------------------------------
    localparam logic [7:0] ERR_ABRT = 8'h04;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int CTL_ID_BIT = 0;
    localparam int CTL_LEVEL_BIT = 8;
    localparam logic [7:0] PW_FIRST_WORD = 8'h01;
    localparam logic [7:0] PW_LAST_WORD = 8'h10;
    localparam logic [7:0] SECTOR_LAST_WORD = 8'hFF;
    localparam int PW_WORDS = 16;

    typedef enum logic [3:0] {
        CAUSE_NONE, CAUSE_SELFTEST_OK, CAUSE_MISC, CAUSE_BAD_ADDR,
        CAUSE_OVERFLOW, CAUSE_UNCORR, CAUSE_CORR, CAUSE_DIAG_FAIL,
        CAUSE_IDNF, CAUSE_SPARE_OUT, CAUSE_ABORTED
    } ats_cause_t;

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_EXEC} ats_phase_t;

    typedef logic [PW_WORDS-1:0][15:0] ats_pw_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ats_bus_t;

    typedef struct packed {
        ats_phase_t phase;
        logic [7:0] cmd;
        logic [7:0] word_cnt;
        logic [15:0] ctl_word;
        ats_pw_t rx_pw;
        ats_pw_t user_pw;
        ats_pw_t master_pw;
        logic user_set;
        logic level_max;
        logic lock_en;
        logic frozen;
        logic prepared;
        logic [7:0] err;
        logic err_flag;
        logic [7:0] sense;
        logic [7:0] sec_count;
        logic [7:0] sec_num;
        logic [7:0] cyl_low;
        logic [7:0] cylinder_high_byte;
        logic [7:0] dev_head;
        logic [7:0] feature;
        logic [15:0] rdata;
        logic intrq;
        logic erase;
        logic wear;
    } ats_state_t;
endpackage
`default_nettype wire

// File: test/ats_core_test.sv
// Self-checking bench of the security and sense command block.
// Assumes the host model in the same folder and the package ats_pkg.
`default_nettype none
module ats_core_test
    import ats_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic nv_init_i = 1'b1;
    logic security_en_i = 1'b1;
    logic sense_evt_i = 1'b0;
    ats_cause_t sense_cause_i = CAUSE_NONE;
    ats_bus_t bus;
    logic [15:0] rdata_o;
    logic intrq_o;
    logic erase_o;
    logic wear_level_o;
    int bad_count = 0;
    int n_tests = 0;
    logic [15:0] exp_q[$];
    logic rd_q = 1'b0;
    logic [7:0] rv;
    logic [15:0] erase_cnt = 16'h0000;
    logic [15:0] wear_cnt = 16'h0000;
    ats_pw_t pw_u, pw_m, pw_x;
    ats_cause_t cz[10] = '{CAUSE_SELFTEST_OK, CAUSE_MISC, CAUSE_BAD_ADDR,
        CAUSE_OVERFLOW, CAUSE_UNCORR, CAUSE_CORR, CAUSE_DIAG_FAIL,
        CAUSE_IDNF, CAUSE_SPARE_OUT, CAUSE_ABORTED};
    logic [7:0] cd[10] = '{8'h01, 8'h09, 8'h21, 8'h2F, 8'h11, 8'h18,
        8'h05, 8'h10, 8'h3A, 8'h1F};

    always #50 clk_i = ~clk_i;

    ats_core i_ats_core (
        .clk_i(clk_i), .srst_i(srst_i), .nv_init_i(nv_init_i),
        .security_en_i(security_en_i), .addr_i(bus.addr),
        .wdata_i(bus.wdata), .wr_i(bus.wr), .rd_i(bus.rd),
        .sense_evt_i(sense_evt_i), .sense_cause_i(sense_cause_i),
        .rdata_o(rdata_o), .intrq_o(intrq_o), .erase_o(erase_o),
        .wear_level_o(wear_level_o)
    );

    ats_host_model i_ats_host_model (.clk_i(clk_i), .bus_o(bus));

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read data is looked at in the one cycle that it stands
    always @(posedge clk_i) begin
        if (rd_q)
            check("read data", exp_q.pop_front(), rdata_o);
        rd_q <= bus.rd;
        if (erase_o === 1'b1)
            erase_cnt <= erase_cnt + 16'h0001;
        if (wear_level_o === 1'b1)
            wear_cnt <= wear_cnt + 16'h0001;
    end

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_ats_host_model.rd(a);
    endtask

    // ----------------------------------------------------------------
    // One command: issue, sector if any, completion, status and error
    // ----------------------------------------------------------------
    task automatic run(input logic [7:0] c, input logic [15:0] ctl,
                       input ats_pw_t pw, input logic [7:0] e);
        int n;
        i_ats_host_model.wr(REG_STAT_CMD, {8'h00, c});
        if (c == CMD_SET_PW || c == CMD_ERASE || c == CMD_DISABLE)
            i_ats_host_model.send_sector(ctl, pw);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (intrq_o !== 1'b1 && n < 20);
        check("interrupt", 16'h0001, {15'h0000, intrq_o});
        // Status read also clears the interrupt before the next command
        rd_chk(REG_STAT_CMD, (e == 8'h00 || c == CMD_SENSE) ?
            16'h0040 : 16'h0041);
        rd_chk(REG_ERR_FEAT, {8'h00, e});
    endtask

    task automatic hw_reset(input logic nv);
        @(posedge clk_i);
        srst_i <= 1'b1;
        nv_init_i <= nv;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        nv_init_i <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h945F8297));
        for (int k = 0; k < 16; k++) begin
            pw_u[k] = 16'($urandom);
            pw_m[k] = 16'($urandom);
        end
        pw_x = pw_u;
        pw_x[15][15] = ~pw_x[15][15];
        hw_reset(1'b1);
        rd_chk(REG_STAT_CMD, 16'h0040);
        for (int a = 2; a < 7; a++) begin
            rv = 8'($urandom);
            i_ats_host_model.wr(3'(a), {8'h00, rv});
            rd_chk(3'(a), {8'h00, rv});
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            sense_cause_i <= cz[i];
            sense_evt_i <= 1'b1;
            @(posedge clk_i);
            sense_evt_i <= 1'b0;
            run(CMD_SENSE, 16'h0, pw_x, cd[i]);
        end
        run(CMD_SENSE, 16'h0000, pw_x, 8'h00);
        run(CMD_ERASE, 16'h0000, pw_x, 8'h04);
        run(CMD_SENSE, 16'h0000, pw_x, 8'h1F);
        run(CMD_SET_PW, 16'h0001, pw_m, 8'h00);
        run(CMD_SET_PW, 16'h0100, pw_u, 8'h00);
        run(CMD_DISABLE, 16'h0001, pw_m, 8'h04);
        run(CMD_DISABLE, 16'h0000, pw_x, 8'h04);
        run(CMD_DISABLE, 16'h0000, pw_u, 8'h00);
        run(CMD_SET_PW, 16'h0000, pw_u, 8'h00);
        run(CMD_PREPARE, 16'h0000, pw_x, 8'h00);
        run(CMD_ERASE, 16'h0000, pw_x, 8'h04);
        run(CMD_PREPARE, 16'h0000, pw_x, 8'h00);
        run(CMD_SENSE, 16'h0000, pw_x, 8'h00);
        run(CMD_ERASE, 16'h0000, pw_u, 8'h04);
        check("erase pulses", 16'h0000, erase_cnt);
        run(CMD_PREPARE, 16'h0000, pw_x, 8'h00);
        run(CMD_ERASE, 16'h0001, pw_m, 8'h00);
        check("erase pulses", 16'h0001, erase_cnt);
        i_ats_host_model.wr(REG_SEC_COUNT, 16'h00FF);
        run(CMD_FREEZE, 16'h0000, pw_x, 8'h00);
        rd_chk(REG_SEC_COUNT, 16'h0000);
        run(CMD_FREEZE, 16'h0000, pw_x, 8'h00);
        run(CMD_SET_PW, 16'h0001, pw_m, 8'h04);
        run(CMD_DISABLE, 16'h0001, pw_m, 8'h04);
        run(CMD_PREPARE, 16'h0000, pw_x, 8'h00);
        run(CMD_ERASE, 16'h0001, pw_m, 8'h04);
        check("erase pulses", 16'h0001, erase_cnt);
        hw_reset(1'b0);
        run(CMD_SET_PW, 16'h0001, pw_m, 8'h00);
        security_en_i <= 1'b0;
        run(CMD_FREEZE, 16'h0000, pw_x, 8'h00);
        check("wear pulses", 16'h0001, wear_cnt);
        security_en_i <= 1'b1;
        run(CMD_SET_PW, 16'h0001, pw_m, 8'h00);
        repeat (4) @(posedge clk_i);
        final_report();
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire

// File: test/ats_host_model.sv
// Host adapter model: drives the task-file port of the command block.
// Assumes the caller steps it from a process that follows the block clock.
`default_nettype none
module ats_host_model
    import ats_pkg::*;
(
    input wire logic clk_i,
    output ats_bus_t bus_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial bus_o = '0;

    // ----------------------------------------------------------------
    // Single accesses
    // ----------------------------------------------------------------
    // Released lines show the inverse so a stale value never matches
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_o.addr <= a;
        bus_o.wdata <= d;
        bus_o.wr <= 1'b1;
        @(posedge clk_i);
        bus_o.wr <= 1'b0;
        bus_o.addr <= ~a;
        bus_o.wdata <= ~d;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        bus_o.addr <= a;
        bus_o.rd <= 1'b1;
        @(posedge clk_i);
        bus_o.rd <= 1'b0;
        bus_o.addr <= ~a;
    endtask

    // ----------------------------------------------------------------
    // Password sector
    // ----------------------------------------------------------------
    task automatic send_sector(input logic [15:0] ctl, input ats_pw_t pw);
        logic [15:0] w;
        for (int k = 0; k < 256; k++) begin
            if (k == 0)
                w = ctl;
            else if (k <= 16)
                w = pw[k-1];
            else
                w = 16'($urandom);
            wr(REG_DATA, w);
        end
    endtask
endmodule
`default_nettype wire
